/* File: ddr_command_timing_guard_tb_top.sv */
// self-checking bench for the ddr command timing guard
module ddr_command_timing_guard_tb_top;
    import dtg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys_i, sys_rst_i, req_valid_i, req_cke_i;
    logic        req_dll_en_i, wr_last_i, req_ready_o, ref_due_o;
    logic        ref_late_o, ras_late_o, mem_cs_n_o, mem_ras_n_o;
    logic        mem_cas_n_o, mem_we_n_o, mem_cke_o, mem_dqs_en_o;
    logic [2:0]  req_cmd_i;
    logic [1:0]  req_bank_i, mem_ba_o;
    logic [12:0] req_addr_i, mem_addr_o;
    int          compares = 0;
    int          miscompares = 0;
    int          cyc = 0;
    int          r0, viol;
    // short refresh and row limits keep the run brief
    dtg_guard #(.REFI_CYC(20), .REFC_CYC(100), .RASMAX_CYC(50)) dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
        .req_bank_i(req_bank_i), .req_addr_i(req_addr_i),
        .req_cke_i(req_cke_i), .req_dll_en_i(req_dll_en_i),
        .wr_last_i(wr_last_i), .req_ready_o(req_ready_o),
        .ref_due_o(ref_due_o), .ref_late_o(ref_late_o),
        .ras_late_o(ras_late_o), .mem_cs_n_o(mem_cs_n_o),
        .mem_ras_n_o(mem_ras_n_o), .mem_cas_n_o(mem_cas_n_o),
        .mem_we_n_o(mem_we_n_o), .mem_cke_o(mem_cke_o),
        .mem_ba_o(mem_ba_o), .mem_addr_o(mem_addr_o),
        .mem_dqs_en_o(mem_dqs_en_o));
    dtg_dram_model #(.AW(13)) u_mem (
        .clk_sys_i(clk_sys_i), .mem_cs_n_i(mem_cs_n_o),
        .mem_ras_n_i(mem_ras_n_o), .mem_cas_n_i(mem_cas_n_o),
        .mem_we_n_i(mem_we_n_o), .mem_cke_i(mem_cke_o),
        .mem_ba_i(mem_ba_o), .mem_addr_i(mem_addr_o), .viol_o(viol));
    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok)
        begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    // holds the request until it shows on the pins; pc is that cycle
    task automatic issue(input logic [2:0] c, input logic [1:0] b,
                         input logic [12:0] a, input bit wl, output int pc);
        int n;
        n = 0;
        req_valid_i = 1'b1;
        req_cmd_i = c;
        req_bank_i = b;
        req_addr_i = a;
        if (wl)
            wr_last_i = 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            #1;
            if (wl && n == 0)
                wr_last_i = 1'b0;
            n++;
        end
        while (mem_cs_n_o !== 1'b0 && n < 400);
        pc = cyc;
        chk(n < 400 && {mem_ras_n_o, mem_cas_n_o, mem_we_n_o} === c
            && mem_ba_o === b && mem_addr_o === a, "command pins");
    endtask : issue
    task automatic quiet();
        req_valid_i = 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask : quiet
    task automatic wait_due();
        int n;
        n = 0;
        while (ref_due_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        chk(ref_due_o === 1'b1, "refresh never due");
    endtask : wait_due
    task automatic t_holdoff();
        int s, p;
        s = cyc;
        issue(DTG_CMD_ACT, 2'h0, 13'h0000, 0, p);
        chk(p - s == 1 && req_ready_o === 1'b1, "activate delayed");
        issue(DTG_CMD_RD, 2'h0, 13'h0004, 0, p);
        chk(p - r0 >= 200 && p - r0 <= 203, "read holdoff");
        chk(ras_late_o === 1'b1, "long open row not flagged");
        chk(ref_late_o === 1'b1, "missed refresh not flagged");
    endtask : t_holdoff
    task automatic t_wtr();
        int s, p;
        s = cyc;
        issue(DTG_CMD_WR, 2'h0, 13'h0008, 0, p);
        chk(p - s == 1, "write delayed");
        quiet();
        chk(mem_dqs_en_o === 1'b1, "no strobe slot");
        s = cyc;
        issue(DTG_CMD_RD, 2'h0, 13'h0010, 1, p);
        chk(p - s >= 2 && p - s <= 3, "write to read gap");
    endtask : t_wtr
    task automatic t_rc();
        int p, p0, p1;
        issue(DTG_CMD_PRE, 2'h0, 13'h0000, 0, p);
        issue(DTG_CMD_ACT, 2'h1, 13'h0020, 0, p0);
        issue(DTG_CMD_PRE, 2'h1, 13'h0000, 0, p1);
        chk(p1 - p0 == 3, "row minimum");
        issue(DTG_CMD_ACT, 2'h1, 13'h0021, 0, p1);
        chk(p1 - p0 == 4, "same bank cycle");
        issue(DTG_CMD_ACT, 2'h2, 13'h0022, 0, p);
        chk(p - p1 == 2, "other bank spacing");
    endtask : t_rc
    task automatic t_rfc();
        int p, pr;
        issue(DTG_CMD_PRE, 2'h3, 13'h0400, 0, p);
        quiet();
        wait_due();
        issue(DTG_CMD_REF, 2'h0, 13'h0000, 0, pr);
        issue(DTG_CMD_ACT, 2'h0, 13'h0030, 0, p);
        chk(p - pr == 4, "refresh period");
        issue(DTG_CMD_PRE, 2'h0, 13'h0000, 0, p);
        issue(DTG_CMD_MRS, 2'h1, 13'h0000, 0, pr);
        issue(DTG_CMD_BST, 2'h0, 13'h0000, 0, p);
        chk(p - pr == 2, "mode load spacing");
        issue(DTG_CMD_NOP, 2'h0, 13'h0000, 0, p);
        quiet();
    endtask : t_rfc
    task automatic t_self();
        int p, x;
        wait_due();
        req_cke_i = 1'b0;
        issue(DTG_CMD_REF, 2'h0, 13'h0000, 0, p);
        chk(mem_cke_o === 1'b0, "self refresh entry");
        quiet();
        repeat (3) @(posedge clk_sys_i);
        #1;
        req_cke_i = 1'b1;
        x = cyc;
        issue(DTG_CMD_ACT, 2'h3, 13'h0040, 0, p);
        chk(p - x >= 4 && p - x <= 6, "self refresh exit");
        quiet();
    endtask : t_self
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        #(3000 * 25);
        miscompares++;
        end_sim();
    end
    initial
    begin
        {clk_sys_i, req_valid_i, wr_last_i} = 3'h0;
        {sys_rst_i, req_cke_i, req_dll_en_i} = 3'h7;
        req_cmd_i = DTG_CMD_NOP;
        req_bank_i = 2'h0;
        req_addr_i = 13'h0000;
        repeat (3) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        r0 = cyc;
        chk(mem_cs_n_o === 1'b1 && mem_cke_o === 1'b0
            && {ref_due_o, ref_late_o, ras_late_o} === 3'h0
            && req_ready_o === 1'b0, "reset state");
        t_holdoff();
        t_wtr();
        t_rc();
        t_rfc();
        t_self();
        chk(viol == 0, "memory saw a timing fault");
        end_sim();
    end
endmodule : ddr_command_timing_guard_tb_top

/* File: dtg_bank_timer.sv */
// per-bank open-row flag and elapsed-cycle counter
module dtg_bank_timer
    import dtg_pkg::*;
#(
    parameter int CW = 24
)(
    input  wire logic          clk_sys_i,
    input  wire logic          sys_rst_i,
    input  wire logic          open_i,
    input  wire logic          close_i,
    output logic               is_open_o,
    output logic [CW-1:0]      age_o
);
    logic          open_r;
    logic          open_nxt;
    logic [CW-1:0] age_r;
    logic [CW-1:0] age_nxt;

    always_comb
    begin
        open_nxt = open_r;
        age_nxt  = age_r;
        if (open_i)
        begin
            open_nxt = 1'b1;
            age_nxt  = '0;
        end
        else
        begin
            if (close_i)
                open_nxt = 1'b0;
            // saturate so a long-idle bank never wraps to "young"
            if (age_r != {CW{1'b1}})
                age_nxt = age_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            open_r <= 1'b0;
            age_r  <= {CW{1'b1}};
        end
        else
        begin
            open_r <= open_nxt;
            age_r  <= age_nxt;
        end
    end

    assign is_open_o = open_r;
    assign age_o     = age_r;
endmodule : dtg_bank_timer

/* File: dtg_cfg.svh */
// timing constants for the ddr command timing guard
`ifndef DTG_CFG_SVH
`define DTG_CFG_SVH

`define DTG_CLK_PS        25000
// fast grade figures in ps
`define DTG_F_RCD_PS      18000
`define DTG_F_RC_PS       60000
`define DTG_F_RFC_PS      72000
`define DTG_F_RAS_MIN_PS  42000
`define DTG_F_RAS_MAX_PS  70000000
`define DTG_F_RRD_PS      12000
`define DTG_F_MRD_PS      12000
`define DTG_F_RAP_PS      18000
// slower grade figures in ps
`define DTG_S_RCD_PS      15000
`define DTG_S_RC_PS       65000
`define DTG_S_RFC_PS      75000
`define DTG_S_RAS_MIN_PS  40000
`define DTG_S_RAS_MAX_PS  120000000
`define DTG_S_RRD_PS      15000
`define DTG_S_MRD_PS      15000
`define DTG_S_RAP_PS      15000
// common figures
`define DTG_XSNR_PS       75000
`define DTG_XSRD_CYC      200
`define DTG_DLL_CYC       200
`define DTG_WTR_CYC       1
`define DTG_REFC_SM_NS    140600
`define DTG_REFC_LG_NS    70300
`define DTG_REFI_SM_NS    15600
`define DTG_REFI_LG_NS    7800
`define DTG_REF_POST_MAX  8
// least times round up, longest round down
`define DTG_CYC_UP(ps)    (((ps) + `DTG_CLK_PS - 1) / `DTG_CLK_PS)
`define DTG_CYC_DN(ps)    ((ps) / `DTG_CLK_PS)
`define DTG_NS_DN(ns)     (((ns) * 1000) / `DTG_CLK_PS)

`endif

/* File: dtg_dram_model.sv */
// memory module model that counts timing faults seen on its pins
module dtg_dram_model
    import dtg_pkg::*;
#(
    parameter int AW   = 13,
    parameter int RC   = 3,
    parameter int RFC  = 3,
    parameter int RAS  = 2,
    parameter int XSNR = 3
)(
    input  wire logic          clk_sys_i,
    input  wire logic          mem_cs_n_i,
    input  wire logic          mem_ras_n_i,
    input  wire logic          mem_cas_n_i,
    input  wire logic          mem_we_n_i,
    input  wire logic          mem_cke_i,
    input  wire logic [1:0]    mem_ba_i,
    input  wire logic [AW-1:0] mem_addr_i,
    output int                 viol_o
);
    int   cyc = 0;
    int   ref_t = -99;
    int   xs_t = -99;
    int   act_t [4] = '{-99, -99, -99, -99};
    bit   open_r [4] = '{0, 0, 0, 0};
    bit   self_r = 0;
    logic cke_q = 1'b0;
    initial viol_o = 0;
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (mem_cke_i && !cke_q && self_r)
        begin
            xs_t = cyc;
            self_r = 0;
        end
        cke_q = mem_cke_i;
        if (!mem_cs_n_i)
        begin
            case ({mem_ras_n_i, mem_cas_n_i, mem_we_n_i})
                DTG_CMD_ACT:
                begin
                    if (open_r[mem_ba_i] || cyc - act_t[mem_ba_i] < RC)
                        viol_o++;
                    if (cyc - ref_t < RFC || cyc - xs_t < XSNR)
                        viol_o++;
                    open_r[mem_ba_i] = 1;
                    act_t[mem_ba_i] = cyc;
                end
                DTG_CMD_RD, DTG_CMD_WR:
                begin
                    if (!open_r[mem_ba_i]
                        || cyc - xs_t < (mem_we_n_i ? 200 : XSNR))
                        viol_o++;
                    if (mem_addr_i[10])
                        open_r[mem_ba_i] = 0;
                end
                DTG_CMD_PRE:
                    for (int b = 0; b < 4; b++)
                        if (mem_addr_i[10] || b == mem_ba_i)
                        begin
                            if (open_r[b] && cyc - act_t[b] < RAS)
                                viol_o++;
                            open_r[b] = 0;
                        end
                DTG_CMD_REF:
                begin
                    for (int b = 0; b < 4; b++)
                        if (open_r[b] || cyc - act_t[b] < RC)
                            viol_o++;
                    ref_t = cyc;
                    self_r = !mem_cke_i;
                end
                default: ;
            endcase
        end
    end
endmodule : dtg_dram_model

/* File: dtg_guard.sv */
// command timing guard between a ddr controller and the memory pins
`include "dtg_cfg.svh"

// Function
// - ACTIVE to READ or WRITE same bank waits 18 ns fast, 15 ns slow.
// - ACTIVE to ACTIVE same bank, or to REFRESH, spaced 60/65 ns.
// - after AUTO REFRESH no bank command for 72/75 ns.
// - row open from ACTIVE to PRECHARGE between 42/40 ns and 70/120 us; the maximum only raises ras_late_o.
// - ACTIVE to ACTIVE on different banks spaced 12/15 ns.
// - after a mode register load, hold next command 12/15 ns.
// - at least one cycle after last write data before READ.
// - after self refresh exit, 200 cycles before first READ.
// - after self refresh exit, 75 ns before any non-READ command; BST is not held.
// - refresh gap never exceeds 140.6 us small or 70.3 us large; a longer gap only raises ref_late_o.
// - average refresh interval at most 15.6 us small, 7.8 us large.
// - first write DQS edge 0.75 to 1.25 clocks after WRITE.
// - READ with auto precharge at least 18/15 ns after ACTIVE.
// - ras, cas, we encode the commands with select low.
// - A10 asks auto precharge on access, all banks on PRECHARGE.
// - after DLL enable, 200 cycles before any READ.
// - refreshes postponed or bunched by at most eight; 64 ms period.
module dtg_guard
    import dtg_pkg::*;
#(
    parameter bit FAST_GRADE = 1'b1,
    parameter bit LARGE_MOD  = 1'b0,
    parameter int AW         = 13,
    parameter int REFI_CYC   = LARGE_MOD ? `DTG_NS_DN(`DTG_REFI_LG_NS)
                                         : `DTG_NS_DN(`DTG_REFI_SM_NS),
    parameter int REFC_CYC   = LARGE_MOD ? `DTG_NS_DN(`DTG_REFC_LG_NS)
                                         : `DTG_NS_DN(`DTG_REFC_SM_NS),
    parameter int RASMAX_CYC = FAST_GRADE ? `DTG_CYC_DN(`DTG_F_RAS_MAX_PS)
                                          : `DTG_CYC_DN(`DTG_S_RAS_MAX_PS)
)(
    input  wire logic          clk_sys_i,
    input  wire logic          sys_rst_i,
    input  wire logic          req_valid_i,
    input  wire logic [2:0]    req_cmd_i,
    input  wire logic [1:0]    req_bank_i,
    input  wire logic [AW-1:0] req_addr_i,
    input  wire logic          req_cke_i,
    input  wire logic          req_dll_en_i,
    input  wire logic          wr_last_i,
    output logic               req_ready_o,
    output logic               ref_due_o,
    output logic               ref_late_o,
    output logic               ras_late_o,
    output logic               mem_cs_n_o,
    output logic               mem_ras_n_o,
    output logic               mem_cas_n_o,
    output logic               mem_we_n_o,
    output logic               mem_cke_o,
    output logic [1:0]         mem_ba_o,
    output logic [AW-1:0]      mem_addr_o,
    output logic               mem_dqs_en_o
);
    // ******************************************************
    // cycle counts
    // ******************************************************
    localparam int CW = 24;
    localparam int RCD = `DTG_CYC_UP(FAST_GRADE ? `DTG_F_RCD_PS
                                                : `DTG_S_RCD_PS);
    localparam int RC  = `DTG_CYC_UP(FAST_GRADE ? `DTG_F_RC_PS
                                                : `DTG_S_RC_PS);
    localparam int RFC = `DTG_CYC_UP(FAST_GRADE ? `DTG_F_RFC_PS
                                                : `DTG_S_RFC_PS);
    localparam int RASN = `DTG_CYC_UP(FAST_GRADE ? `DTG_F_RAS_MIN_PS
                                                 : `DTG_S_RAS_MIN_PS);
    localparam int RRD = `DTG_CYC_UP(FAST_GRADE ? `DTG_F_RRD_PS
                                                : `DTG_S_RRD_PS);
    localparam int MRD = `DTG_CYC_UP(FAST_GRADE ? `DTG_F_MRD_PS
                                                : `DTG_S_MRD_PS);
    localparam int RAP = `DTG_CYC_UP(FAST_GRADE ? `DTG_F_RAP_PS
                                                : `DTG_S_RAP_PS);
    localparam int XSNR = `DTG_CYC_UP(`DTG_XSNR_PS);

    // ******************************************************
    // per-bank state
    // ******************************************************
    logic [3:0]    act_b;
    logic [3:0]    pre_b;
    logic [3:0]    open_b;
    logic [CW-1:0] age_b [4];

    for (genvar g = 0; g < 4; g++)
    begin : g_bank
        dtg_bank_timer #(.CW(CW)) u_bank (
            .clk_sys_i (clk_sys_i),
            .sys_rst_i (sys_rst_i),
            .open_i    (act_b[g]),
            .close_i   (pre_b[g]),
            .is_open_o (open_b[g]),
            .age_o     (age_b[g])
        );
    end

    // ******************************************************
    // global timers
    // ******************************************************
    dtg_state_t    st_r,      st_nxt;
    logic [CW-1:0] since_act_r, since_act_nxt;
    logic [CW-1:0] since_ref_r, since_ref_nxt;
    logic [CW-1:0] since_mrs_r, since_mrs_nxt;
    logic [CW-1:0] since_xsr_r, since_xsr_nxt;
    logic [CW-1:0] since_dll_r, since_dll_nxt;
    logic [CW-1:0] since_wr_r,  since_wr_nxt;
    logic [CW-1:0] credit_r,    credit_nxt;
    logic [4:0]    owed_r,      owed_nxt;
    logic          go;
    logic          ok;
    logic          rd_ok;
    logic          any_open;
    logic [CW-1:0] bage;

    function automatic logic [CW-1:0] inc(input logic [CW-1:0] v);
        inc = (v == {CW{1'b1}}) ? v : v + 1'b1;
    endfunction : inc

    assign any_open = |open_b;
    assign bage     = age_b[req_bank_i];

    always_comb
    begin
        ok    = 1'b1;
        rd_ok = (since_dll_r >= CW'(`DTG_DLL_CYC))
              && (since_xsr_r >= CW'(`DTG_XSRD_CYC))
              && !wr_last_i && (since_wr_r >= CW'(`DTG_WTR_CYC));
        if (since_mrs_r < CW'(MRD))
            ok = 1'b0;
        if (since_ref_r < CW'(RFC))
            ok = 1'b0;
        // nothing but deselect while the module refreshes itself
        if (st_r == DTG_ST_SELF)
            ok = 1'b0;
        unique case (dtg_cmd_t'(req_cmd_i))
            DTG_CMD_ACT:
                ok = ok && !open_b[req_bank_i]
                     && bage >= CW'(RC)
                     && since_act_r >= CW'(RRD)
                     && since_xsr_r >= CW'(XSNR);
            DTG_CMD_RD:
                ok = ok && rd_ok && open_b[req_bank_i]
                     && bage >= CW'(RCD)
                     && (!req_addr_i[10] || bage >= CW'(RAP));
            DTG_CMD_WR:
                ok = ok && open_b[req_bank_i] && bage >= CW'(RCD)
                     && since_xsr_r >= CW'(XSNR);
            DTG_CMD_PRE:
                // all-bank close checks every open row
                ok = ok && since_xsr_r >= CW'(XSNR)
                     && (req_addr_i[10]
                         ? ((!open_b[0] || age_b[0] >= CW'(RASN))
                            && (!open_b[1] || age_b[1] >= CW'(RASN))
                            && (!open_b[2] || age_b[2] >= CW'(RASN))
                            && (!open_b[3] || age_b[3] >= CW'(RASN)))
                         : bage >= CW'(RASN));
            DTG_CMD_REF:
                ok = ok && !any_open && since_xsr_r >= CW'(XSNR)
                     && (age_b[0] >= CW'(RC)) && (age_b[1] >= CW'(RC))
                     && (age_b[2] >= CW'(RC))
                     && (age_b[3] >= CW'(RC))
                     && owed_r != 5'h0;
            DTG_CMD_MRS:
                ok = ok && !any_open && since_xsr_r >= CW'(XSNR);
            default:
                ok = ok;
        endcase
        go = req_valid_i && ok;
    end

    always_comb
    begin
        act_b = '0;
        pre_b = '0;
        if (go && req_cmd_i == DTG_CMD_ACT)
            act_b[req_bank_i] = 1'b1;
        if (go && req_cmd_i == DTG_CMD_PRE)
            pre_b = req_addr_i[10] ? 4'hf : (4'h1 << req_bank_i);
        // auto precharge closes the bank after the access
        if (go && req_addr_i[10]
            && (req_cmd_i == DTG_CMD_RD || req_cmd_i == DTG_CMD_WR))
            pre_b[req_bank_i] = 1'b1;
    end

    always_comb
    begin
        st_nxt        = st_r;
        since_act_nxt = inc(since_act_r);
        since_ref_nxt = inc(since_ref_r);
        since_mrs_nxt = inc(since_mrs_r);
        since_xsr_nxt = inc(since_xsr_r);
        since_dll_nxt = inc(since_dll_r);
        since_wr_nxt  = inc(since_wr_r);
        credit_nxt    = credit_r + 1'b1;
        owed_nxt      = owed_r;
        // one refresh owed per average interval, at most eight banked
        if (credit_r >= CW'(REFI_CYC - 1))
        begin
            credit_nxt = '0;
            if (owed_r != 5'(`DTG_REF_POST_MAX))
                owed_nxt = owed_r + 1'b1;
        end
        if (go && req_cmd_i == DTG_CMD_ACT)
            since_act_nxt = '0;
        if (go && req_cmd_i == DTG_CMD_MRS)
            since_mrs_nxt = '0;
        if (wr_last_i)
            since_wr_nxt = '0;
        if (!req_dll_en_i)
            since_dll_nxt = '0;
        if (go && req_cmd_i == DTG_CMD_REF)
        begin
            since_ref_nxt = '0;
            if (owed_nxt != 5'h0)
                owed_nxt = owed_nxt - 1'b1;
            if (!req_cke_i)
                st_nxt = DTG_ST_SELF;
        end
        if (st_r == DTG_ST_SELF)
        begin
            // refresh is internal; the refresh gap restarts at exit
            since_ref_nxt = CW'(RFC);
            credit_nxt    = '0;
            if (req_cke_i)
            begin
                st_nxt        = DTG_ST_RUN;
                since_xsr_nxt = '0;
            end
        end
        else if (st_r == DTG_ST_IDLE)
            st_nxt = DTG_ST_RUN;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r        <= DTG_ST_IDLE;
            since_act_r <= {CW{1'b1}};
            since_ref_r <= {CW{1'b1}};
            since_mrs_r <= {CW{1'b1}};
            since_xsr_r <= {CW{1'b1}};
            since_dll_r <= '0;
            since_wr_r  <= {CW{1'b1}};
            credit_r    <= '0;
            owed_r      <= 5'h0;
        end
        else
        begin
            st_r        <= st_nxt;
            since_act_r <= since_act_nxt;
            since_ref_r <= since_ref_nxt;
            since_mrs_r <= since_mrs_nxt;
            since_xsr_r <= since_xsr_nxt;
            since_dll_r <= since_dll_nxt;
            since_wr_r  <= since_wr_nxt;
            credit_r    <= credit_nxt;
            owed_r      <= owed_nxt;
        end
    end

    // ******************************************************
    // pin stage
    // ******************************************************
    logic          cs_n_nxt, ras_n_nxt, cas_n_nxt, we_n_nxt;
    logic          dqs_nxt, due_nxt, late_nxt, rlate_nxt;

    always_comb
    begin
        cs_n_nxt  = !go;
        {ras_n_nxt, cas_n_nxt, we_n_nxt} = go ? req_cmd_i : 3'h7;
        // strobe window opens the cycle after WRITE: one clock later
        dqs_nxt   = !mem_cs_n_o
                    && {mem_ras_n_o, mem_cas_n_o, mem_we_n_o}
                       == DTG_CMD_WR;
        due_nxt   = owed_r != 5'h0;
        late_nxt  = st_r != DTG_ST_SELF
                    && since_ref_r >= CW'(REFC_CYC);
        rlate_nxt = (open_b[0] && age_b[0] >= CW'(RASMAX_CYC))
                    || (open_b[1] && age_b[1] >= CW'(RASMAX_CYC))
                    || (open_b[2] && age_b[2] >= CW'(RASMAX_CYC))
                    || (open_b[3] && age_b[3] >= CW'(RASMAX_CYC));
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            mem_cs_n_o   <= 1'b1;
            mem_ras_n_o  <= 1'b1;
            mem_cas_n_o  <= 1'b1;
            mem_we_n_o   <= 1'b1;
            mem_cke_o    <= 1'b0;
            mem_ba_o     <= 2'h0;
            mem_addr_o   <= '0;
            mem_dqs_en_o <= 1'b0;
            req_ready_o  <= 1'b0;
            ref_due_o    <= 1'b0;
            ref_late_o   <= 1'b0;
            ras_late_o   <= 1'b0;
        end
        else
        begin
            mem_cs_n_o   <= cs_n_nxt;
            mem_ras_n_o  <= ras_n_nxt;
            mem_cas_n_o  <= cas_n_nxt;
            mem_we_n_o   <= we_n_nxt;
            mem_cke_o    <= req_cke_i;
            mem_ba_o     <= req_bank_i;
            mem_addr_o   <= req_addr_i;
            mem_dqs_en_o <= dqs_nxt;
            req_ready_o  <= ok;
            ref_due_o    <= due_nxt;
            ref_late_o   <= late_nxt;
            ras_late_o   <= rlate_nxt;
        end
    end
endmodule : dtg_guard

/* File: dtg_guard_monitor.sv */
// port checker for the ddr command timing guard
module dtg_guard_monitor
    import dtg_pkg::*;
#(
    parameter int AW = 13
)(
    input wire logic          clk_sys_i,
    input wire logic          sys_rst_i,
    input wire logic          req_valid_i,
    input wire logic [2:0]    req_cmd_i,
    input wire logic [1:0]    req_bank_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic          req_dll_en_i,
    input wire logic          wr_last_i,
    input wire logic          mem_cs_n_o,
    input wire logic          mem_ras_n_o,
    input wire logic          mem_cas_n_o,
    input wire logic          mem_we_n_o,
    input wire logic [1:0]    mem_ba_o,
    input wire logic [AW-1:0] mem_addr_o,
    input wire logic          mem_dqs_en_o
);
    logic [2:0] pin_cmd;
    logic       act_w, rd_w, wr_w, pre_w, ref_w, busy_w;
    logic [7:0] dll_cnt_r, dll_cnt_nxt;
    assign pin_cmd = {mem_ras_n_o, mem_cas_n_o, mem_we_n_o};
    assign act_w = !mem_cs_n_o && pin_cmd == DTG_CMD_ACT;
    assign rd_w = !mem_cs_n_o && pin_cmd == DTG_CMD_RD;
    assign wr_w = !mem_cs_n_o && pin_cmd == DTG_CMD_WR;
    assign pre_w = !mem_cs_n_o && pin_cmd == DTG_CMD_PRE;
    assign ref_w = !mem_cs_n_o && pin_cmd == DTG_CMD_REF;
    assign busy_w = !mem_cs_n_o && pin_cmd != DTG_CMD_NOP
                    && pin_cmd != DTG_CMD_BST;
    // saturates so a long run never wraps below the read limit
    always_comb
    begin
        dll_cnt_nxt = dll_cnt_r;
        if (!req_dll_en_i)
            dll_cnt_nxt = 8'h00;
        else if (dll_cnt_r != 8'hff)
            dll_cnt_nxt = dll_cnt_r + 8'h01;
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            dll_cnt_r <= 8'h00;
        else
            dll_cnt_r <= dll_cnt_nxt;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    cmd_echo_a: assert property (
        !mem_cs_n_o |-> $past(req_valid_i) && pin_cmd == $past(req_cmd_i)
        && mem_ba_o == $past(req_bank_i) && mem_addr_o == $past(req_addr_i))
        else $error("pins differ from the taken request");
    bank_cycle_a: assert property (
        act_w |=> !(act_w && mem_ba_o == $past(mem_ba_o))
        ##1 !(act_w && mem_ba_o == $past(mem_ba_o, 2)))
        else $error("same bank activated too soon");
    act_ref_a: assert property (act_w |=> !ref_w [*2])
        else $error("refresh too soon after activate");
    ref_hold_a: assert property (ref_w |=> !busy_w [*2])
        else $error("bank command too soon after refresh");
    row_min_a: assert property (
        act_w |=> !(pre_w && (mem_addr_o[10] || mem_ba_o == $past(mem_ba_o))))
        else $error("row closed too soon");
    wtr_gap_a: assert property (wr_last_i |=> !rd_w)
        else $error("read too soon after write data");
    dqs_pulse_a: assert property (wr_w |=> mem_dqs_en_o)
        else $error("strobe enable missing after write");
    dqs_cause_a: assert property (mem_dqs_en_o |-> $past(wr_w))
        else $error("strobe enable without write");
    dll_hold_a: assert property (rd_w |-> dll_cnt_r >= 8'hc9)
        else $error("read before delay lock settled");
endmodule : dtg_guard_monitor

bind dtg_guard dtg_guard_monitor #(.AW(AW)) u_mon (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_bank_i(req_bank_i), .req_addr_i(req_addr_i),
    .req_dll_en_i(req_dll_en_i), .wr_last_i(wr_last_i),
    .mem_cs_n_o(mem_cs_n_o), .mem_ras_n_o(mem_ras_n_o),
    .mem_cas_n_o(mem_cas_n_o), .mem_we_n_o(mem_we_n_o),
    .mem_ba_o(mem_ba_o), .mem_addr_o(mem_addr_o),
    .mem_dqs_en_o(mem_dqs_en_o));

/* File: dtg_pkg.sv */
// types for the ddr command timing guard
package dtg_pkg;
    // {ras_n, cas_n, we_n} with select low
    typedef enum logic [2:0] {
        DTG_CMD_NOP  = 3'h7,
        DTG_CMD_ACT  = 3'h3,
        DTG_CMD_RD   = 3'h5,
        DTG_CMD_WR   = 3'h4,
        DTG_CMD_BST  = 3'h6,
        DTG_CMD_PRE  = 3'h2,
        DTG_CMD_REF  = 3'h1,
        DTG_CMD_MRS  = 3'h0
    } dtg_cmd_t;

    typedef enum logic [1:0] {
        DTG_ST_IDLE = 2'b00,
        DTG_ST_RUN  = 2'b01,
        DTG_ST_SELF = 2'b11
    } dtg_state_t;
endpackage : dtg_pkg
